// file: core/seu_core.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: overrun/conflict flags, standby and a byte shifter behind apb
// Assumes: link pins asynchronous, sampled on pclk
// Notes:   zero wait state apb slave, unmapped access answers pslverr
//////////////////////////////////////////////////////////////////////////////
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module seu_core #(
   parameter int unsigned HALF_DIV = seu_pkg::DEF_HALF_DIV
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [seu_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output var  logic [31:0]                 prdata,
   output var  logic                        pready,
   output var  logic                        pslverr,
   input  wire seu_pkg::seu_pin_in_t        pins_in,
   output var  seu_pkg::seu_pin_out_t       pins_out
);
   import seu_pkg::*;

   function automatic logic hit(input logic [15:0] w, input logic [15:0] idx);
      hit = (w == idx);
   endfunction

   logic       master_slave_select, four_line, awake;
   logic       overrun, rx_full, conflict;
   logic       arm_ovr, arm_rxf, arm_ce;
   logic [7:0] tx_data, rx_data, rx_shift, tx_shift;
   logic [2:0] bit_cnt;
   logic       m_busy, m_last, sck_q;
   logic [15:0] div_cnt;
   logic [2:0] pin_s;
   logic       sck_d, cs_d;

   //////////////////////////////////////////////////////////////////////////
   // link pin synchronisation
   seu_sync #(.WIDTH(3)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({pins_in.sck, pins_in.sdi, pins_in.cs_n}),
      .q     (pin_s)
   );
   wire sck_s = pin_s[2];
   wire sdi_s = pin_s[1];
   wire cs_s  = pin_s[0];

   // previous synchronised levels for edge finding
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_d <= 1'b0;
         cs_d  <= 1'b0;
      end else begin
         sck_d <= sck_s;
         cs_d  <= cs_s;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // apb decode
   wire [15:0] widx   = paddr[ADDR_W-1:2];
   wire        setup  = psel & ~penable;
   wire        wr     = psel & penable & pwrite;
   wire        rd     = psel & penable & ~pwrite;
   wire        hit_ctl = hit(widx, IDX_CONTROL);
   wire        hit_sts = hit(widx, IDX_STATUS);
   wire        hit_rx  = hit(widx, IDX_RX_DATA);
   wire        hit_tx  = hit(widx, IDX_TX_DATA);
   wire        hit_hlt = hit(widx, IDX_CLK_HALT);
   wire        hit_any = hit_ctl | hit_sts | hit_rx | hit_tx | hit_hlt;
   wire        wr_sts  = wr & hit_sts;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   // read data selection
   wire [7:0] st_val = {1'b0, overrun, 3'h0, 1'b0, rx_full, conflict};
   wire [7:0] rd_mux = hit_ctl ? {master_slave_select, four_line, 6'h00} :
                       hit_sts ? st_val :
                       hit_rx  ? rx_data :
                       hit_tx  ? tx_data :
                       hit_hlt ? {3'h0, awake, 4'h0} : 8'h00;

   // read word captured in the setup cycle
   // arming below uses this word, so a flag that rises after the setup
   // cycle reads 0 here and cannot be cleared by the write that follows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= {24'h00_0000, rd_mux};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // transfer start and conflict detection
   wire start_req  = wr & hit_ctl & pwdata[CTL_START];
   wire ce_master  = start_req & master_slave_select & four_line & ~cs_s & awake;
   wire m_start_ok = start_req & master_slave_select & awake & ~m_busy & ~overrun & ~ce_master;
   wire ce_slave   = ~master_slave_select & four_line & awake & cs_s & ~cs_d & (bit_cnt != 3'h0);
   wire set_ce     = ce_master | ce_slave;

   // master clock divider ticks
   // tick marks every half period of the serial clock while busy
   wire tick     = m_busy & (div_cnt == 16'(HALF_DIV - 1));
   wire m_sample = tick & ~sck_q;
   wire m_end    = tick & sck_q & m_last;

   // slave sampling, frozen by overrun or standby
   // edges come from the synchronised clock, so the link clock must be
   // well below pclk for every edge to be seen
   wire s_active = ~master_slave_select & awake & ~overrun & (four_line ? ~cs_s : 1'b1);
   wire s_sample = s_active & sck_s & ~sck_d;
   wire sample   = m_sample | s_sample;
   wire rx_done  = sample & (bit_cnt == 3'(WORD_BITS - 1));
   wire [7:0] rx_word = {rx_shift[6:0], sdi_s};
   wire s_load   = ~master_slave_select & four_line & ~cs_s & cs_d;

   //////////////////////////////////////////////////////////////////////////
   // master clock generator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_busy  <= 1'b0;
         m_last  <= 1'b0;
         sck_q   <= 1'b0;
         div_cnt <= 16'h0000;
      end else if (!awake || set_ce) begin
         m_busy  <= 1'b0;
         m_last  <= 1'b0;
         sck_q   <= 1'b0;
         div_cnt <= 16'h0000;
      end else begin
         if (m_start_ok)
            m_busy <= 1'b1;
         else if (m_end)
            m_busy <= 1'b0;
         m_last  <= m_end ? 1'b0 : (m_last | (m_sample & rx_done));
         sck_q   <= tick ? ~sck_q : sck_q;
         div_cnt <= (tick || !m_busy) ? 16'h0000 : div_cnt + 16'h0001;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // shift registers and bit counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_shift <= 8'h00;
         tx_shift <= 8'h00;
         bit_cnt  <= 3'h0;
      end else if (!awake || ce_slave) begin
         bit_cnt  <= 3'h0;
      end else begin
         if (sample) begin
            rx_shift <= rx_word;
            bit_cnt  <= bit_cnt + 3'h1;
         end
         if (m_start_ok || s_load || (s_sample && rx_done))
            tx_shift <= tx_data;
         else if (sample)
            tx_shift <= {tx_shift[6:0], 1'b0};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // flag update terms, a set always beats a clear
   wire set_ovr = rx_done & rx_full;
   wire set_rxf = rx_done & ~rx_full;
   wire clr_ovr = wr_sts & ~pwdata[STS_OVR] & arm_ovr;
   wire clr_ce  = wr_sts & ~pwdata[STS_CE] & arm_ce;
   wire clr_rxf = (wr_sts & ~pwdata[STS_RXF] & arm_rxf) | (rd & hit_rx);
   wire next_overrun  = set_ovr | (overrun & ~clr_ovr);
   wire next_conflict = set_ce | (conflict & ~clr_ce);
   wire next_rx_full  = set_rxf | (rx_full & ~clr_rxf);

   // status flags and clear arming by status reads
   // any status write disarms, so a stale read cannot clear a later flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun  <= 1'b0;
         conflict <= 1'b0;
         rx_full  <= 1'b0;
         arm_ovr  <= 1'b0;
         arm_ce   <= 1'b0;
         arm_rxf  <= 1'b0;
      end else begin
         overrun  <= next_overrun;
         conflict <= next_conflict;
         rx_full  <= next_rx_full;
         if (rd && hit_sts) begin
            arm_ovr <= prdata[STS_OVR];
            arm_ce  <= prdata[STS_CE];
            arm_rxf <= prdata[STS_RXF];
         end else if (wr_sts) begin
            arm_ovr <= 1'b0;
            arm_ce  <= 1'b0;
            arm_rxf <= 1'b0;
         end
      end
   end

   // receive data register keeps the old word on overrun
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rx_data <= 8'h00;
      else if (set_rxf)
         rx_data <= rx_word;
   end

   //////////////////////////////////////////////////////////////////////////
   // control, transmit data and standby registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_slave_select       <= RST_MSS;
         four_line <= RST_FOUR;
         awake     <= RST_RUN;
         tx_data   <= RST_TX;
      end else begin
         if (set_ce)
            master_slave_select <= 1'b0;
         else if (wr && hit_ctl)
            master_slave_select <= pwdata[CTL_MSS];
         if (wr && hit_ctl)
            four_line <= pwdata[CTL_FOUR];
         if (wr && hit_hlt)
            awake <= pwdata[HLT_RUN];
         if (wr && hit_tx)
            tx_data <= pwdata[7:0];
      end
   end

   // pin drivers
   // both enables drop in standby so the pins float to the board pulls
   assign pins_out.sck    = sck_q;
   assign pins_out.sck_oe = master_slave_select & awake;
   assign pins_out.sdo    = tx_shift[7];
   assign pins_out.sdo_oe = awake & (master_slave_select | ~four_line | ~cs_s);

   //////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_overrun_set: assert property (rx_done && rx_full |=> overrun)
      else $error("overrun not set by completion while full");
   chk_rx_keep: assert property (rx_done && rx_full |=> rx_data == $past(rx_data))
      else $error("receive data overwritten on overrun");
   chk_no_rx_ovr: assert property (overrun && !master_slave_select |-> !rx_done)
      else $error("reception completed while overrun set");
   chk_no_tx_ovr: assert property (start_req && overrun && !m_busy |=> !m_busy)
      else $error("master started while overrun set");
   chk_ce_master: assert property (start_req && master_slave_select && four_line && !cs_s && awake |=> conflict && !master_slave_select)
      else $error("master conflict not flagged");
   chk_ce_slave: assert property (!master_slave_select && four_line && awake && $rose(cs_s) && bit_cnt != 3'h0 |=> conflict)
      else $error("slave conflict not flagged");
   chk_clear_ok: assert property (arm_ovr && wr_sts && !pwdata[STS_OVR] && !set_ovr |=> !overrun)
      else $error("overrun not cleared by write zero after read one");
   chk_write_one: assert property (conflict && wr_sts && pwdata[STS_CE] |=> conflict)
      else $error("conflict cleared by writing one");
   chk_no_arm: assert property (overrun && wr_sts && !arm_ovr |=> overrun)
      else $error("overrun cleared without prior read");
   chk_standby_hold: assert property (!awake |=> !m_busy && bit_cnt == 3'h0)
      else $error("unit active in standby");
   chk_rx_full_set: assert property (rx_done && !rx_full |=> rx_full && rx_data == $past(rx_word))
      else $error("normal reception not stored");

   cov_overrun: cover property ($rose(overrun));
   cov_conflict_m: cover property (ce_master);
   cov_conflict_s: cover property (ce_slave);
   cov_master_word: cover property (m_end ##1 rx_full);
   cov_clear: cover property (clr_ovr);

   // further guards on the flag and pin paths
   chk_tx_gate: assert property (overrun |-> !m_start_ok)
      else $error("master start passed while overrun set");
   chk_ce_demote: assert property (set_ce |=> !master_slave_select)
      else $error("master select kept after conflict");
   chk_ovr_cause: assert property (!overrun && !set_ovr |=> !overrun)
      else $error("overrun set without a completion");
   chk_ce_cause: assert property (!conflict && !set_ce |=> !conflict)
      else $error("conflict set without a cause");
   chk_ce_sticky: assert property (conflict && !clr_ce |=> conflict)
      else $error("conflict dropped without a clear");
   chk_ovr_sticky: assert property (overrun && !clr_ovr |=> overrun)
      else $error("overrun dropped without a clear");
   chk_arm_read: assert property (rd && hit_sts |=> arm_ce == $past(prdata[STS_CE]))
      else $error("conflict clear not armed by status read");
   chk_rx_freeze: assert property (overrun |-> !s_sample)
      else $error("slave edge taken while overrun set");
   chk_standby_oe: assert property (!awake |-> !pins_out.sck_oe && !pins_out.sdo_oe)
      else $error("pins driven in standby");
   chk_slave_cut: assert property (ce_slave |=> bit_cnt == 3'h0)
      else $error("bit count kept after slave conflict");
endmodule
`default_nettype wire

// file: core/seu_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants and carriers for the serial unit error/status block
// Assumes: apb word index = printed offset, byte address = 4 * index
// Notes:   register data sit in bits 7:0, upper bits read zero
//
// What this block does
// - a reception that completes while rx_full_flag is 1 sets overrun_flag (status bit 6).
// - on overrun the receive data register keeps its old word and the new word is dropped.
// - while overrun_flag is 1 no further reception takes place.
// - as master, overrun_flag at 1 also blocks further transmission.
// - four-line master start with the slave select pin low sets the conflict flag (status bit 0).
// - four-line slave sees slave select rise during a transfer and sets the conflict flag.
// - the error flags clear only by writing 0 after reading 1 there.
// - standby bit 4 at 0 puts the unit in standby, at 1 releases it.
// - setting the conflict flag clears master_slave_select, back to slave.
// - a normal reception moves the word into the receive data register and sets rx_full_flag.
//////////////////////////////////////////////////////////////////////////////
package seu_pkg;
   localparam int unsigned ADDR_W = 18;
   // register word indices
   localparam logic [15:0] IDX_CONTROL  = 16'hF0E0;
   localparam logic [15:0] IDX_STATUS   = 16'hF0E4;
   localparam logic [15:0] IDX_RX_DATA  = 16'hF0E9;
   localparam logic [15:0] IDX_TX_DATA  = 16'hF0EB;
   localparam logic [15:0] IDX_CLK_HALT = 16'hFFFB;
   // field positions
   localparam int unsigned CTL_MSS   = 7;
   localparam int unsigned CTL_FOUR  = 6;
   localparam int unsigned CTL_START = 0;
   localparam int unsigned STS_OVR   = 6;
   localparam int unsigned STS_RXF   = 1;
   localparam int unsigned STS_CE    = 0;
   localparam int unsigned HLT_RUN   = 4;
   // reset values
   localparam logic       RST_MSS  = 1'b0;
   localparam logic       RST_FOUR = 1'b1;
   localparam logic       RST_RUN  = 1'b1;
   localparam logic [7:0] RST_TX   = 8'h00;
   // timing
   localparam int unsigned WORD_BITS    = 8;
   localparam int unsigned DEF_HALF_DIV = 16;

   typedef struct packed {
      logic sck;
      logic sdi;
      logic cs_n;
   } seu_pin_in_t;

   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic sdo;
      logic sdo_oe;
   } seu_pin_out_t;
endpackage

// file: core/seu_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-stage synchroniser for link pins
// Assumes: inputs asynchronous to clk
// Notes:   only q may be read by other logic
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module seu_sync #(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // two flops in a row, nothing taps the first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// file: tb/seu_peer.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: peer serial master driving the link pins of the unit
// Assumes: link clock period 160 ns, held low between frames
// Notes:   a frame shorter than 8 bits raises select early
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module seu_peer (
   output var seu_pkg::seu_pin_in_t pins
);
   import seu_pkg::*;
   logic last;

   // idle pins: clock low, select pulled high
   initial begin
      pins = '{sck: 1'b0, sdi: 1'b0, cs_n: 1'b1};
      last = 1'b0;
   end

   // select held by hand for conflict cases
   task automatic hold(input logic v);
      pins.cs_n = v;
   endtask

   // one frame msb first, data changes while clock is low
   task automatic send(input logic [7:0] d, input int nb);
      pins.cs_n = 1'b0;
      for (int i = 7; i > 7 - nb; i--) begin
         pins.sdi = d[i];
         last = d[i];
         #80 pins.sck = 1'b1;
         #80 pins.sck = 1'b0;
      end
      #80 pins.cs_n = 1'b1;
      pins.sdi = ~last;   // released line shows no stale bit
      #400;
   endtask
endmodule
`default_nettype wire

// file: tb/seu_core_bench.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the error/status flags over apb
// Assumes: peer master on the link, zero wait state apb slave
// Notes:   HALF_DIV shortened to 2
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module seu_core_bench;
   import seu_pkg::*;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0]   paddr;
   logic [31:0]         pwdata, prdata;
   logic [7:0]          rd;
   seu_pin_in_t         pins_in;
   seu_pin_out_t        pins_out;
   int                  n_errors, checks_done;

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end

   seu_core #(.HALF_DIV(2)) seu_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out));
   seu_peer seu_peer_inst (.pins(pins_in));

   //////////////////////////////////////////////////////////////////////////
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [15:0] idx, input logic [7:0] e, input string nm);
      apb(1'b0, idx, 8'h00);
      `CHK(nm, e, rd)
   endtask

   // serial clock must stay low for a while
   task automatic quiet_sck(input string nm);
      int seen;
      seen = 0;
      repeat (80) @(negedge pclk) if (pins_out.sck !== 1'b0) seen++;
      `CHK(nm, 0, seen)
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rchk(IDX_CONTROL, 8'h40, "control reset");
      rchk(IDX_STATUS, 8'h00, "status reset");
      rchk(IDX_CLK_HALT, 8'h10, "halt reset");
      apb(1'b1, IDX_TX_DATA, 8'hC3);
      rchk(IDX_TX_DATA, 8'hC3, "tx data");
      apb(1'b0, 16'h0000, 8'h00);
      `CHK("unmapped err", 1'b1, err)
      $display("test regs done");
   endtask

   task automatic t_overrun();
      seu_peer_inst.send(8'hA5, 8);
      rchk(IDX_STATUS, 8'h02, "rx full");
      seu_peer_inst.send(8'h3C, 8);
      rchk(IDX_STATUS, 8'h42, "overrun set");
      seu_peer_inst.send(8'h0F, 8);
      rchk(IDX_RX_DATA, 8'hA5, "rx kept");
      rchk(IDX_STATUS, 8'h40, "overrun sticky");
      seu_peer_inst.send(8'h77, 8);
      rchk(IDX_STATUS, 8'h40, "rx blocked");
      rchk(IDX_RX_DATA, 8'hA5, "rx still kept");
      $display("test overrun done");
   endtask

   task automatic t_mst_block();
      apb(1'b1, IDX_CONTROL, 8'hC0);
      @(negedge pclk);
      `CHK("master sck oe", 1'b1, pins_out.sck_oe)
      apb(1'b1, IDX_CONTROL, 8'hC1);
      quiet_sck("tx blocked");
      rchk(IDX_STATUS, 8'h40, "no conflict");
      apb(1'b1, IDX_CONTROL, 8'h40);
      $display("test master block done");
   endtask

   task automatic t_clear();
      apb(1'b1, IDX_STATUS, 8'h40);
      apb(1'b1, IDX_STATUS, 8'h00);
      rchk(IDX_STATUS, 8'h40, "clear unarmed");
      apb(1'b1, IDX_STATUS, 8'h00);
      rchk(IDX_STATUS, 8'h00, "overrun clear");
      $display("test clear done");
   endtask

   task automatic t_conflict();
      seu_peer_inst.hold(1'b0);
      repeat (10) @(posedge pclk);
      apb(1'b1, IDX_CONTROL, 8'hC0);
      apb(1'b1, IDX_CONTROL, 8'hC1);
      quiet_sck("start refused");
      rchk(IDX_STATUS, 8'h01, "master conflict");
      rchk(IDX_CONTROL, 8'h40, "back to slave");
      seu_peer_inst.hold(1'b1);
      apb(1'b1, IDX_STATUS, 8'h00);
      rchk(IDX_STATUS, 8'h00, "conflict clear");
      seu_peer_inst.send(8'h55, 3);
      rchk(IDX_STATUS, 8'h01, "slave conflict");
      apb(1'b1, IDX_STATUS, 8'h00);
      rchk(IDX_STATUS, 8'h00, "conflict clear 2");
      $display("test conflict done");
   endtask

   task automatic t_standby();
      apb(1'b1, IDX_CLK_HALT, 8'h00);
      rchk(IDX_CLK_HALT, 8'h00, "halt write");
      @(negedge pclk);
      `CHK("standby sdo oe", 1'b0, pins_out.sdo_oe)
      seu_peer_inst.send(8'h5A, 8);
      rchk(IDX_STATUS, 8'h00, "standby idle");
      apb(1'b1, IDX_CLK_HALT, 8'h10);
      seu_peer_inst.send(8'h5A, 8);
      rchk(IDX_STATUS, 8'h02, "awake rx");
      rchk(IDX_RX_DATA, 8'h5A, "awake data");
      $display("test standby done");
   endtask

   //////////////////////////////////////////////////////////////////////////
   // free running clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // reset, then the tests in order
   initial begin
      {presetn, psel, penable, pwrite, err} = '0;
      paddr = '0;
      pwdata = '0;
      rd = '0;
      n_errors = 0;
      checks_done = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_overrun();
      t_mst_block();
      t_clear();
      t_conflict();
      t_standby();
      end_of_test();
   end

   // watchdog well beyond the expected run
   initial begin
      #200000;
      n_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
